// ==== design/csa_pkg.sv ====
package csa_pkg;
    // ----------------------------------------------------------------
    // Frame and slot geometry
    // ----------------------------------------------------------------
    localparam int unsigned SAMPLE_W = 24;
    localparam int unsigned CNT_W = 10;
    localparam int unsigned PTR_W = 5;
    localparam logic [CNT_W-1:0] LAST_DATA_BIT = 10'h017;
    localparam logic [CNT_W-1:0] RATIO_LOW = 10'h100;
    localparam logic [CNT_W-1:0] RATIO_HIGH = 10'h200;
    localparam logic [CNT_W-1:0] RATIO_DS = 10'h100;
    localparam logic [CNT_W-1:0] N_256 = 10'h100;
    localparam logic [CNT_W-1:0] N_512 = 10'h200;
    // ----------------------------------------------------------------
    // Path latencies in frame periods
    // ----------------------------------------------------------------
    localparam logic [PTR_W-1:0] LAT_AUDIO_SS = 5'h0b;
    localparam logic [PTR_W-1:0] LAT_AUDIO_DS = 5'h07;
    localparam logic [PTR_W-1:0] LAT_SHORT = 5'h02;
    localparam logic [PTR_W-1:0] FRAMES_SAT = 5'h1f;
    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h0;
endpackage

// ==== design/csa_delay_mem.sv ====
`timescale 1ns/100ps
module csa_delay_mem (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [csa_pkg::PTR_W-1:0] wr_addr,
    input wire logic [csa_pkg::SAMPLE_W-1:0] wr_data,
    input wire logic [csa_pkg::PTR_W-1:0] rd_addr,
    output logic [csa_pkg::SAMPLE_W-1:0] rd_data_ff
);
    logic [csa_pkg::SAMPLE_W-1:0] mem_ff [0:(1<<csa_pkg::PTR_W)-1];
    logic [csa_pkg::SAMPLE_W-1:0] nxt_rd_data;

    always_comb begin
        nxt_rd_data = mem_ff[rd_addr];
    end

    // Storage is not reset; reads of unwritten entries are never delivered.
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end
endmodule

// ==== design/csa_tdm_core.sv ====
`timescale 1ns/100ps
// Functional notes
// - First slot MSB on second rise after sync.
// - n is the configured master clock ratio.
// - Output bits launched on bit clock fall.
// - Input bits captured on bit clock rise.
// - Audio path latency 11 or 7 frames.
// - Tracking path matches base audio latency (no added latency) or short hold.
// - Low-latency path takes 2 or 2.5 frames.
// - Added latency field adds to audio path.
// - Latency counted from frame sync rise.
module csa_tdm_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bit_clock,
    input wire logic frame_sync,
    input wire logic serial_data_in,
    output logic serial_data_out,
    input wire logic double_speed,
    input wire logic ratio_512,
    input wire logic [3:0] added_latency,
    input wire logic tracking_hold_mode,
    input wire logic [csa_pkg::SAMPLE_W-1:0] tx_sample,
    output logic [csa_pkg::SAMPLE_W-1:0] analog_outputs,
    output logic analog_outputs_valid,
    output logic [csa_pkg::SAMPLE_W-1:0] tracking_out,
    output logic tracking_out_valid,
    output logic [csa_pkg::SAMPLE_W-1:0] low_latency_out,
    output logic low_latency_out_valid,
    output logic sync_width_err,
    output logic frame_ratio_err
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [csa_pkg::SYNC_STAGES-1:0] sclk_sync_ff, fs_sync_ff, sdin_sync_ff;
    logic [2:0] pin_lvl_ff, nxt_pin_lvl, pin_agree;
    logic sclk_rise, sclk_fall, fs_now, sdin_now;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_sync_ff <= csa_pkg::SYNC_RESET;
            fs_sync_ff <= csa_pkg::SYNC_RESET;
            sdin_sync_ff <= csa_pkg::SYNC_RESET;
            pin_lvl_ff <= '0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], bit_clock};
            fs_sync_ff <= {fs_sync_ff[1:0], frame_sync};
            sdin_sync_ff <= {sdin_sync_ff[1:0], serial_data_in};
            pin_lvl_ff <= nxt_pin_lvl;
        end
    end

    // A pin level is taken only once stages two and three agree, so a lone stage-two flip is never acted on.
    assign pin_agree = ~({sdin_sync_ff[1], fs_sync_ff[1], sclk_sync_ff[1]} ^ {sdin_sync_ff[2], fs_sync_ff[2],
                       sclk_sync_ff[2]});
    assign nxt_pin_lvl = ({sdin_sync_ff[2], fs_sync_ff[2], sclk_sync_ff[2]} & pin_agree) | (pin_lvl_ff & ~pin_agree);
    assign sclk_rise = nxt_pin_lvl[0] & ~pin_lvl_ff[0];
    assign sclk_fall = ~nxt_pin_lvl[0] & pin_lvl_ff[0];
    assign fs_now = pin_lvl_ff[1];
    assign sdin_now = pin_lvl_ff[2];

    // ----------------------------------------------------------------
    // Frame tracking, capture and launch
    // ----------------------------------------------------------------
    logic [csa_pkg::CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
    logic [csa_pkg::CNT_W-1:0] frame_len_ff, nxt_frame_len;
    logic [csa_pkg::CNT_W-1:0] fs_high_ff, nxt_fs_high;
    logic [csa_pkg::SAMPLE_W-1:0] rx_shift_ff, nxt_rx_shift;
    logic [csa_pkg::SAMPLE_W-1:0] tx_shift_ff, nxt_tx_shift;
    logic [csa_pkg::PTR_W-1:0] frame_cnt_ff, nxt_frame_cnt;
    logic [csa_pkg::PTR_W-1:0] frames_seen_ff, nxt_frames_seen;
    logic fs_prev_ff, nxt_fs_prev, started_ff, nxt_started, sdout_ff, nxt_sdout;
    logic width_err_ff, nxt_width_err, ratio_err_ff, nxt_ratio_err;
    logic frame_start, half_point, sample_done;
    logic [csa_pkg::CNT_W-1:0] n_bound;
    logic [csa_pkg::PTR_W-1:0] lat_fixed, lat_audio;

    assign frame_start = sclk_rise & fs_now & ~fs_prev_ff;
    assign half_point = sclk_rise & started_ff & ~frame_start
                        & (bit_cnt_ff == (frame_len_ff >> 1) - 10'h001);
    assign sample_done = sclk_rise & started_ff & ~frame_start & (bit_cnt_ff == csa_pkg::LAST_DATA_BIT);
    assign n_bound = ratio_512 ? csa_pkg::N_512 : csa_pkg::N_256;
    assign lat_fixed = double_speed ? csa_pkg::LAT_AUDIO_DS : csa_pkg::LAT_AUDIO_SS;
    assign lat_audio = lat_fixed + {1'b0, added_latency};

    always_comb begin
        nxt_bit_cnt = bit_cnt_ff;
        nxt_frame_len = frame_len_ff;
        nxt_fs_high = fs_high_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_frame_cnt = frame_cnt_ff;
        nxt_frames_seen = frames_seen_ff;
        nxt_fs_prev = fs_prev_ff;
        nxt_started = started_ff;
        nxt_sdout = sdout_ff;
        nxt_width_err = 1'b0;
        nxt_ratio_err = 1'b0;
        if (sclk_rise) begin
            nxt_fs_prev = fs_now;
            if (frame_start) begin
                nxt_bit_cnt = '0;
                nxt_fs_high = 10'h001;
                nxt_tx_shift = tx_sample;
                nxt_started = 1'b1;
                if (started_ff) begin
                    nxt_frame_len = bit_cnt_ff + 10'h001;
                    nxt_frame_cnt = frame_cnt_ff + 5'h01;
                    if (frames_seen_ff != csa_pkg::FRAMES_SAT) begin
                        nxt_frames_seen = frames_seen_ff + 5'h01;
                    end
                    if (!double_speed && (nxt_frame_len < csa_pkg::RATIO_LOW || nxt_frame_len > csa_pkg::RATIO_HIGH)) begin
                        nxt_ratio_err = 1'b1;
                    end
                    if (double_speed && nxt_frame_len != csa_pkg::RATIO_DS) begin
                        nxt_ratio_err = 1'b1;
                    end
                end
            end else begin
                nxt_bit_cnt = bit_cnt_ff + 10'h001;
                if (fs_now) begin
                    nxt_fs_high = fs_high_ff + 10'h001;
                end
                if (!fs_now && fs_prev_ff && fs_high_ff > n_bound - 10'h001) begin
                    nxt_width_err = 1'b1;
                end
                if (started_ff && bit_cnt_ff <= csa_pkg::LAST_DATA_BIT) begin
                    nxt_rx_shift = {rx_shift_ff[csa_pkg::SAMPLE_W-2:0], sdin_now};
                end
            end
        end
        if (sclk_fall) begin
            if (started_ff && bit_cnt_ff <= csa_pkg::LAST_DATA_BIT) begin
                nxt_sdout = tx_shift_ff[csa_pkg::SAMPLE_W-1];
                nxt_tx_shift = {tx_shift_ff[csa_pkg::SAMPLE_W-2:0], 1'b0};
            end else begin
                nxt_sdout = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_cnt_ff <= '0;
            frame_len_ff <= csa_pkg::N_256;
            fs_high_ff <= '0;
            rx_shift_ff <= '0;
            tx_shift_ff <= '0;
            frame_cnt_ff <= '0;
            frames_seen_ff <= '0;
            fs_prev_ff <= 1'b0;
            started_ff <= 1'b0;
            sdout_ff <= 1'b0;
            width_err_ff <= 1'b0;
            ratio_err_ff <= 1'b0;
        end else begin
            bit_cnt_ff <= nxt_bit_cnt;
            frame_len_ff <= nxt_frame_len;
            fs_high_ff <= nxt_fs_high;
            rx_shift_ff <= nxt_rx_shift;
            tx_shift_ff <= nxt_tx_shift;
            frame_cnt_ff <= nxt_frame_cnt;
            frames_seen_ff <= nxt_frames_seen;
            fs_prev_ff <= nxt_fs_prev;
            started_ff <= nxt_started;
            sdout_ff <= nxt_sdout;
            width_err_ff <= nxt_width_err;
            ratio_err_ff <= nxt_ratio_err;
        end
    end

    assign serial_data_out = sdout_ff;
    assign sync_width_err = width_err_ff;
    assign frame_ratio_err = ratio_err_ff;

    // ----------------------------------------------------------------
    // Latency lines
    // ----------------------------------------------------------------
    // Each frame's sample lands in one slot; three copies trade area for independent read ages.
    logic [csa_pkg::SAMPLE_W-1:0] wr_sample;
    logic [csa_pkg::PTR_W-1:0] rd_audio, rd_fixed, rd_short;
    logic [csa_pkg::SAMPLE_W-1:0] q_audio, q_fixed, q_short;
    logic audio_req, fixed_req, short_req;

    assign wr_sample = {rx_shift_ff[csa_pkg::SAMPLE_W-2:0], sdin_now};
    assign rd_audio = nxt_frame_cnt - lat_audio;
    assign rd_fixed = nxt_frame_cnt - lat_fixed;
    assign rd_short = frame_cnt_ff - csa_pkg::LAT_SHORT;
    // Ages include the frame now starting, so the first captured frame is delivered as well.
    assign audio_req = frame_start & started_ff & (nxt_frames_seen >= lat_audio);
    assign fixed_req = frame_start & started_ff & (nxt_frames_seen >= lat_fixed);
    // short path, half frame later in double speed
    assign short_req = double_speed ? (half_point & (frames_seen_ff >= csa_pkg::LAT_SHORT))
                       : (frame_start & started_ff & (nxt_frames_seen >= csa_pkg::LAT_SHORT));

    csa_delay_mem u_mem_audio (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(sample_done),
        .wr_addr(frame_cnt_ff),
        .wr_data(wr_sample),
        .rd_addr(rd_audio),
        .rd_data_ff(q_audio)
    );
    csa_delay_mem u_mem_fixed (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(sample_done),
        .wr_addr(frame_cnt_ff),
        .wr_data(wr_sample),
        .rd_addr(rd_fixed),
        .rd_data_ff(q_fixed)
    );
    csa_delay_mem u_mem_short (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(sample_done),
        .wr_addr(double_speed ? frame_cnt_ff : frame_cnt_ff),
        .wr_data(wr_sample),
        .rd_addr(double_speed ? rd_short : nxt_frame_cnt - csa_pkg::LAT_SHORT),
        .rd_data_ff(q_short)
    );

    // ----------------------------------------------------------------
    // Path outputs
    // ----------------------------------------------------------------
    logic audio_pend_ff, fixed_pend_ff, short_pend_ff;
    logic [csa_pkg::SAMPLE_W-1:0] audio_ff, nxt_audio, track_ff, nxt_track, low_ff, nxt_low;
    logic audio_v_ff, nxt_audio_v, track_v_ff, nxt_track_v, low_v_ff, nxt_low_v;

    always_comb begin
        nxt_audio = audio_ff;
        nxt_track = track_ff;
        nxt_low = low_ff;
        nxt_audio_v = audio_pend_ff;
        nxt_low_v = short_pend_ff;
        nxt_track_v = tracking_hold_mode ? short_pend_ff : fixed_pend_ff;
        if (audio_pend_ff) begin
            nxt_audio = q_audio;
        end
        if (short_pend_ff) begin
            nxt_low = q_short;
        end
        if (nxt_track_v) begin
            nxt_track = tracking_hold_mode ? q_short : q_fixed;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            audio_pend_ff <= 1'b0;
            fixed_pend_ff <= 1'b0;
            short_pend_ff <= 1'b0;
            audio_ff <= '0;
            track_ff <= '0;
            low_ff <= '0;
            audio_v_ff <= 1'b0;
            track_v_ff <= 1'b0;
            low_v_ff <= 1'b0;
        end else begin
            audio_pend_ff <= audio_req;
            fixed_pend_ff <= fixed_req;
            short_pend_ff <= short_req;
            audio_ff <= nxt_audio;
            track_ff <= nxt_track;
            low_ff <= nxt_low;
            audio_v_ff <= nxt_audio_v;
            track_v_ff <= nxt_track_v;
            low_v_ff <= nxt_low_v;
        end
    end

    assign analog_outputs = audio_ff;
    assign analog_outputs_valid = audio_v_ff;
    assign tracking_out = track_ff;
    assign tracking_out_valid = track_v_ff;
    assign low_latency_out = low_ff;
    assign low_latency_out_valid = low_v_ff;
endmodule

// ==== tb/csa_tdm_props.sv ====
`timescale 1ns/100ps
module csa_tdm_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bit_clock,
    input wire logic frame_sync,
    input wire logic serial_data_out,
    input wire logic double_speed,
    input wire logic [csa_pkg::SAMPLE_W-1:0] analog_outputs,
    input wire logic analog_outputs_valid,
    input wire logic tracking_out_valid,
    input wire logic [csa_pkg::SAMPLE_W-1:0] low_latency_out,
    input wire logic low_latency_out_valid,
    input wire logic sync_width_err,
    input wire logic frame_ratio_err
);
    // ----------------------------------------------------------------
    // Link timing properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_start_seen;
        $past(frame_sync, 4);
    endsequence
    sequence s_audio_quiet;
        !analog_outputs_valid [*8];
    endsequence
    a_audio_at_start: assert property (analog_outputs_valid |-> $past(frame_sync, 5))
        else $error("audio sample away from frame start");
    a_audio_spacing: assert property (analog_outputs_valid |=> s_audio_quiet)
        else $error("audio valid repeated too soon");
    a_audio_hold: assert property ($changed(analog_outputs) |-> analog_outputs_valid)
        else $error("audio data changed without valid");
    a_ll_hold: assert property ($changed(low_latency_out) |-> low_latency_out_valid)
        else $error("low latency data changed without valid");
    a_ll_mid_frame: assert property (double_speed && low_latency_out_valid |-> !$past(frame_sync, 5))
        else $error("double speed low latency sample at frame start");
    a_ll_ss_start: assert property (!double_speed && low_latency_out_valid |-> $past(frame_sync, 5))
        else $error("single speed low latency sample away from frame start");
    a_dout_on_fall: assert property ($changed(serial_data_out) |-> !$past(bit_clock, 2))
        else $error("serial output changed after a bit clock rise");
    a_ratio_at_start: assert property (frame_ratio_err |-> s_start_seen)
        else $error("frame ratio flag away from frame start");
    a_sync_err_late: assert property (sync_width_err |-> !$past(frame_sync, 1) ##1 !sync_width_err)
        else $error("sync width flag while sync high or too long");
    a_track_spacing: assert property (tracking_out_valid |=> !tracking_out_valid [*8])
        else $error("tracking valid repeated too soon");
    // A synchronous reset must clear the audio and low-latency valids and the serial output at the next edge.
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !analog_outputs_valid && !serial_data_out
        && !low_latency_out_valid) else $error("outputs not cleared by reset");
endmodule

// ==== tb/csa_host.sv ====
`timescale 1ns/100ps
module csa_host (
    input wire logic sys_clk,
    output logic bit_clock,
    output logic frame_sync,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    // ----------------------------------------------------------------
    // Host side of the link
    // ----------------------------------------------------------------
    int frame_no = -1;
    int bit_no = 0;
    int stray_ones = 0;
    logic [23:0] rx_word = 24'h000000;
    initial begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        serial_data_in = 1'b0;
    end
    // slow clock, set length.
    // Path and transmit frames are 32 bits, far shorter than real ones, so the run stays brief.
    task automatic send_frame(input int len, input int width, input logic [23:0] word);
        frame_no++;
        for (int b = 0; b < len; b++) begin
            bit_no = b;
            bit_clock = 1'b0;
            frame_sync = 1'(b < width);
            serial_data_in = (b >= 1 && b <= 24) ? word[24-b] : b[0];
            repeat (4) @(negedge sys_clk);
            bit_clock = 1'b1;
            repeat (4) @(negedge sys_clk);
            if (b >= 1 && b <= 24) begin
                rx_word[24-b] = serial_data_out;
            end else if (b > 24 && serial_data_out !== 1'b0) begin
                stray_ones++;
            end
        end
    endtask
endmodule

// ==== tb/codec_serial_audio_timing_tb.sv ====
`timescale 1ns/100ps
module codec_serial_audio_timing_tb;
    logic sys_clk, rst, bit_clock, frame_sync, serial_data_in, serial_data_out;
    logic double_speed, ratio_512, tracking_hold_mode, analog_outputs_valid, tracking_out_valid;
    logic low_latency_out_valid, sync_width_err, frame_ratio_err;
    logic [3:0] added_latency;
    logic [23:0] tx_sample, analog_outputs, tracking_out, low_latency_out;
    int failures = 0;
    int checks_done = 0;
    int n_audio, n_track, n_ll, n_sync, n_ratio;
    csa_tdm_core dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .bit_clock(bit_clock),
        .frame_sync(frame_sync),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .double_speed(double_speed),
        .ratio_512(ratio_512),
        .added_latency(added_latency),
        .tracking_hold_mode(tracking_hold_mode),
        .tx_sample(tx_sample),
        .analog_outputs(analog_outputs),
        .analog_outputs_valid(analog_outputs_valid),
        .tracking_out(tracking_out),
        .tracking_out_valid(tracking_out_valid),
        .low_latency_out(low_latency_out),
        .low_latency_out_valid(low_latency_out_valid),
        .sync_width_err(sync_width_err),
        .frame_ratio_err(frame_ratio_err)
    );
    csa_host host (
        .sys_clk(sys_clk),
        .bit_clock(bit_clock),
        .frame_sync(frame_sync),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out)
    );
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic [31:0] word(input int f);
        return 32'(24'h5a0000 + 24'(f));
    endfunction
    task automatic do_reset();
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        host.frame_no = -1;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic run_tx();
        tx_sample = 24'hc35a96;
        do_reset();
        host.send_frame(32, 1, 24'h000000);
        check("first slot out", 32'(host.rx_word), 32'h00c35a96);
        tx_sample = 24'h800001;
        host.send_frame(32, 1, 24'h000000);
        check("next frame out", 32'(host.rx_word), 32'h00800001);
        check("other slots", 32'(host.stray_ones), 32'h0);
    endtask
    task automatic run_paths(input logic ds, input logic hold, input logic [3:0] add);
        int la;
        int lt;
        la = (ds ? 7 : 11) + int'(add);
        lt = hold ? 2 : (ds ? 7 : 11);
        double_speed = ds;
        tracking_hold_mode = hold;
        added_latency = add;
        do_reset();
        n_audio = 0;
        n_track = 0;
        n_ll = 0;
        fork
            repeat (la + 2) host.send_frame(32, 1, word(host.frame_no + 1));
            repeat ((la + 2) * 256) begin
                @(posedge sys_clk);
                #1;
                if (analog_outputs_valid === 1'b1) begin
                    n_audio++;
                    check("audio data", 32'(analog_outputs), word(host.frame_no - la));
                    check("audio slot", 32'(host.bit_no <= 1), 32'h1);
                end
                if (tracking_out_valid === 1'b1) begin
                    n_track++;
                    check("track data", 32'(tracking_out), word(host.frame_no - lt));
                end
                if (low_latency_out_valid === 1'b1) begin
                    n_ll++;
                    check("low data", 32'(low_latency_out), word(host.frame_no - 2));
                    check("low slot", 32'(ds ? (host.bit_no == 16 || host.bit_no == 17) : host.bit_no <= 1),
                          32'h1);
                end
            end
        join
        check("audio count", 32'(n_audio), 32'h2);
        check("track count", 32'(n_track), 32'(la + 2 - lt));
        check("low count", 32'(n_ll), 32'(la));
    endtask
    task automatic run_framing();
        int lens[8] = '{300, 300, 300, 255, 513, 512, 257, 256};
        int wids[8] = '{255, 256, 256, 1, 1, 1, 1, 1};
        logic [7:0] ds_set = 8'hc0;
        logic [7:0] r512_set = 8'h04;
        logic [7:0] sync_set = 8'h02;
        logic [7:0] ratio_set = 8'h58;
        for (int i = 0; i < 8; i++) begin
            double_speed = ds_set[i];
            ratio_512 = r512_set[i];
            do_reset();
            n_sync = 0;
            n_ratio = 0;
            fork
                begin
                    host.send_frame(lens[i], wids[i], 24'h000000);
                    host.send_frame(32, 1, 24'h000000);
                end
                repeat (lens[i] * 8 + 256) begin
                    @(posedge sys_clk);
                    #1;
                    n_sync += int'(sync_width_err === 1'b1);
                    n_ratio += int'(frame_ratio_err === 1'b1);
                end
            join
            check("sync width flag", 32'(n_sync), 32'(sync_set[i]));
            check("frame ratio flag", 32'(n_ratio), 32'(ratio_set[i]));
        end
    endtask
    // ----------------------------------------------------------------
    // Clock, sequence and watchdog
    // ----------------------------------------------------------------
    // master clock in range.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        double_speed = 1'b0;
        ratio_512 = 1'b0;
        added_latency = 4'h0;
        tracking_hold_mode = 1'b0;
        tx_sample = 24'h000000;
        do_reset();
        check("reset outputs", 32'({analog_outputs, serial_data_out, sync_width_err, frame_ratio_err}), 32'h0);
        run_tx();
        run_paths(1'b0, 1'b0, 4'h4);
        run_paths(1'b0, 1'b1, 4'hf);
        run_paths(1'b1, 1'b0, 4'h0);
        run_paths(1'b1, 1'b1, 4'h1);
        run_framing();
        close_out();
    end
    // The full sequence needs about 41000 cycles; this allows ample margin.
    initial begin
        #3000000;
        failures++;
        close_out();
    end
endmodule
bind csa_tdm_core csa_tdm_props u_props (
    .sys_clk(sys_clk),
    .rst(rst),
    .bit_clock(bit_clock),
    .frame_sync(frame_sync),
    .serial_data_out(serial_data_out),
    .double_speed(double_speed),
    .analog_outputs(analog_outputs),
    .analog_outputs_valid(analog_outputs_valid),
    .tracking_out_valid(tracking_out_valid),
    .low_latency_out(low_latency_out),
    .low_latency_out_valid(low_latency_out_valid),
    .sync_width_err(sync_width_err),
    .frame_ratio_err(frame_ratio_err)
);
